// ### design/sbl_loader_top.sv
// sbl_loader_top: packet command interpreter of the serial boot loader
// assumes: byte-level async and clocked serial ports outside; flash
// erase and byte program engines answer with done pulses
//
// Overview of operation
// - first byte is total packet length
// - second byte is payload byte sum
// - exactly length minus two payload bytes
// - answer 0xCC on success, 0x33 on failure
// - answer depends only on reception
// - zero bytes may precede any packet
// - outgoing packet bytes sent without gaps
// - first non-zero host byte is its answer
// - first payload byte is the command
// - one-byte probe sets last result to success
// - result query returns one-byte result packet
// - setup carries address then count, MSB first
// - setup erases whole range before answering
// - setup validity stored as last result
// - payload only after setup, addresses continue
// - session ends when byte count reached
// - NAKed payload leaves address unchanged
// - jump acknowledged before control passes
// - restart acknowledged before software reset
// - first used port locks out the other
// - async frame 8N1, outside this block
// - two 0x55 bytes answered with 0xCC
`timescale 1ns/100ps
`default_nettype none
`include "sbl_params.svh"

module sbl_loader_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic uart_rx_valid,
  input wire logic [7:0] uart_rx_data,
  input wire logic uart_tx_ready,
  output logic uart_tx_valid,
  input wire logic ssi_rx_valid,
  input wire logic [7:0] ssi_rx_data,
  input wire logic ssi_tx_ready,
  output logic ssi_tx_valid,
  output logic [7:0] tx_data,
  output logic flash_erase_req,
  output logic [31:0] flash_erase_addr,
  output logic [31:0] flash_erase_size,
  input wire logic flash_erase_done,
  output logic flash_wr_req,
  output logic [31:0] flash_wr_addr,
  output logic [7:0] flash_wr_data,
  input wire logic flash_wr_done,
  output logic run_req,
  output logic [31:0] run_addr,
  output logic soft_reset
);

  sbl_pkg::sbl_state_type state;
  sbl_pkg::sbl_port_type port_sel;
  sbl_pkg::sbl_post_type post;
  logic [1:0] tx_vec;
  logic [1:0] sync_cnt;
  logic [7:0] last_result;
  logic [31:0] prog_addr;
  logic [31:0] prog_left;
  logic prog_active;
  logic [7:0] pidx;
  logic [1:0] bidx;
  logic sel_valid;
  logic [7:0] sel_data;
  logic [1:0] port_vec;
  logic tx_take;
  logic sync_hit;
  logic [31:0] dl_addr;
  logic [31:0] dl_size;
  logic dl_ok;

  sbl_pkt_if pkt ();

  // ----------------------------------------------------------------------
  // port selection and byte steering
  // ----------------------------------------------------------------------
  // an unlocked loader listens to the clocked port for packets
  always_comb begin
    sel_valid = (port_sel == sbl_pkg::PORT_UART) ? uart_rx_valid
                                                  : ssi_rx_valid;
    sel_data = (port_sel == sbl_pkg::PORT_UART) ? uart_rx_data
                                                 : ssi_rx_data;
  end

  assign port_vec = {port_sel == sbl_pkg::PORT_SSI,
                     port_sel == sbl_pkg::PORT_UART};
  assign tx_take = (tx_vec[0] && uart_tx_ready) ||
                   (tx_vec[1] && ssi_tx_ready);
  assign sync_hit = state == sbl_pkg::S_RX &&
                    port_sel == sbl_pkg::PORT_NONE && uart_rx_valid &&
                    uart_rx_data == `SBL_SYNC_BYTE &&
                    sync_cnt == `SBL_SYNC_COUNT - 2'h1;
  assign uart_tx_valid = tx_vec[0];
  assign ssi_tx_valid = tx_vec[1];

  assign pkt.enable = state == sbl_pkg::S_RX;
  assign pkt.byte_valid = sel_valid;
  assign pkt.byte_data = sel_data;

  sbl_packet_rx u_rx (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pkt(pkt)
  );

  // setup parameters, MSB first
  assign dl_addr = {pkt.payload[1], pkt.payload[2],
                    pkt.payload[3], pkt.payload[4]};
  assign dl_size = {pkt.payload[5], pkt.payload[6],
                    pkt.payload[7], pkt.payload[8]};
  assign dl_ok = dl_size != 32'h0000_0000 &&
                 dl_addr <= `SBL_FLASH_BYTES &&
                 dl_size <= `SBL_FLASH_BYTES - dl_addr;

  // ----------------------------------------------------------------------
  // port lock
  // ----------------------------------------------------------------------
  // sync pattern locks the async port, any non-zero byte the clocked one
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      port_sel <= sbl_pkg::PORT_NONE;
      sync_cnt <= 2'h0;
    end else if (port_sel == sbl_pkg::PORT_NONE &&
                 state == sbl_pkg::S_RX) begin
      if (ssi_rx_valid && ssi_rx_data != 8'h00) begin
        port_sel <= sbl_pkg::PORT_SSI;
      end else if (sync_hit) begin
        port_sel <= sbl_pkg::PORT_UART;
      end else if (uart_rx_valid) begin
        sync_cnt <= (uart_rx_data == `SBL_SYNC_BYTE) ?
                    sync_cnt + 2'h1 : 2'h0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------------
  // receives, executes, answers and sends the result packet
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= sbl_pkg::S_RX;
      post <= sbl_pkg::POST_NONE;
      tx_vec <= 2'b00;
      tx_data <= 8'h00;
      last_result <= `SBL_RES_SUCCESS;
      prog_addr <= 32'h0000_0000;
      prog_left <= 32'h0000_0000;
      prog_active <= 1'b0;
      pidx <= 8'h00;
      bidx <= 2'h0;
      flash_erase_req <= 1'b0;
      flash_erase_addr <= 32'h0000_0000;
      flash_erase_size <= 32'h0000_0000;
      flash_wr_req <= 1'b0;
      flash_wr_addr <= 32'h0000_0000;
      flash_wr_data <= 8'h00;
      run_req <= 1'b0;
      run_addr <= 32'h0000_0000;
      soft_reset <= 1'b0;
    end else begin
      run_req <= 1'b0;
      soft_reset <= 1'b0;
      unique case (state)
        sbl_pkg::S_RX: begin
          if (sync_hit) begin
            tx_data <= `SBL_ACK_BYTE;
            tx_vec <= 2'b01;
            state <= sbl_pkg::S_SYNC;
          end else if (pkt.done) begin
            // answer reflects reception only
            tx_data <= pkt.good ? `SBL_ACK_BYTE : `SBL_NAK_BYTE;
            tx_vec <= port_vec;
            state <= sbl_pkg::S_ACK;
            post <= sbl_pkg::POST_NONE;
            if (pkt.good) begin
              case (pkt.payload[0])
                `SBL_CMD_PING: begin
                  last_result <= (pkt.count == `SBL_PING_PAYLOAD) ?
                    `SBL_RES_SUCCESS : `SBL_RES_INVALID_CMD;
                end
                `SBL_CMD_STATUS: begin
                  post <= sbl_pkg::POST_STATUS;
                end
                `SBL_CMD_DOWNLOAD: begin
                  prog_active <= 1'b0;
                  if (pkt.count != `SBL_DOWNLOAD_PAYLOAD) begin
                    last_result <= `SBL_RES_INVALID_CMD;
                  end else if (!dl_ok) begin
                    last_result <= `SBL_RES_INVALID_ADDR;
                  end else begin
                    last_result <= `SBL_RES_SUCCESS;
                    prog_addr <= dl_addr;
                    prog_left <= dl_size;
                    flash_erase_addr <= dl_addr;
                    flash_erase_size <= dl_size;
                    flash_erase_req <= 1'b1;
                    tx_vec <= 2'b00;
                    state <= sbl_pkg::S_ERASE;
                  end
                end
                `SBL_CMD_SEND_DATA: begin
                  if (!prog_active || pkt.count < 8'h02 ||
                      pkt.count > `SBL_MAX_DATA + 8'h01) begin
                    last_result <= `SBL_RES_INVALID_CMD;
                  end else begin
                    last_result <= `SBL_RES_SUCCESS;
                    pidx <= 8'h01;
                    tx_vec <= 2'b00;
                    state <= sbl_pkg::S_PROG;
                  end
                end
                `SBL_CMD_RUN: begin
                  if (pkt.count == `SBL_RUN_PAYLOAD) begin
                    run_addr <= {pkt.payload[1], pkt.payload[2],
                                 pkt.payload[3], pkt.payload[4]};
                    post <= sbl_pkg::POST_RUN;
                  end else begin
                    last_result <= `SBL_RES_INVALID_CMD;
                  end
                end
                `SBL_CMD_RESET: begin
                  post <= sbl_pkg::POST_RESET;
                end
                default: begin
                  last_result <= `SBL_RES_UNKNOWN_CMD;
                end
              endcase
            end
          end
        end
        sbl_pkg::S_ERASE: begin
          if (flash_erase_done) begin
            flash_erase_req <= 1'b0;
            prog_active <= 1'b1;
            tx_data <= `SBL_ACK_BYTE;
            tx_vec <= port_vec;
            state <= sbl_pkg::S_ACK;
          end
        end
        sbl_pkg::S_PROG: begin
          if (flash_wr_req) begin
            if (flash_wr_done) begin
              flash_wr_req <= 1'b0;
              prog_addr <= prog_addr + 32'h0000_0001;
              prog_left <= prog_left - 32'h0000_0001;
              pidx <= pidx + 8'h01;
            end
          end else if (pidx < pkt.count && prog_left != 32'h0000_0000) begin
            flash_wr_req <= 1'b1;
            flash_wr_addr <= prog_addr;
            flash_wr_data <= pkt.payload[pidx[3:0]];
          end else begin
            prog_active <= prog_left != 32'h0000_0000;
            tx_data <= `SBL_ACK_BYTE;
            tx_vec <= port_vec;
            state <= sbl_pkg::S_ACK;
          end
        end
        sbl_pkg::S_ACK: begin
          if (tx_take) begin
            tx_vec <= 2'b00;
            state <= sbl_pkg::S_RX;
            unique case (post)
              sbl_pkg::POST_NONE: begin
              end
              sbl_pkg::POST_STATUS: begin
                tx_data <= `SBL_STATUS_LEN;
                tx_vec <= port_vec;
                bidx <= 2'h0;
                state <= sbl_pkg::S_PKT;
              end
              sbl_pkg::POST_RUN: begin
                run_req <= 1'b1;
              end
              sbl_pkg::POST_RESET: begin
                soft_reset <= 1'b1;
              end
            endcase
          end
        end
        sbl_pkg::S_PKT: begin
          // sum of a one-byte payload is the byte itself
          if (tx_take) begin
            bidx <= bidx + 2'h1;
            tx_data <= last_result;
            if (bidx == 2'h2) begin
              tx_vec <= 2'b00;
              state <= sbl_pkg::S_HOST;
            end
          end
        end
        sbl_pkg::S_HOST: begin
          if (sel_valid && sel_data != 8'h00) begin
            state <= sbl_pkg::S_RX;
          end
        end
        sbl_pkg::S_SYNC: begin
          if (tx_take) begin
            tx_vec <= 2'b00;
            state <= sbl_pkg::S_RX;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence bad_packet_s;
    state == sbl_pkg::S_RX && !sync_hit && pkt.done && !pkt.good;
  endsequence

  sequence ack_taken_s;
    state == sbl_pkg::S_ACK && tx_take && tx_data == `SBL_ACK_BYTE;
  endsequence

  answer_value_a: assert property (
    state == sbl_pkg::S_ACK |->
      tx_data == `SBL_ACK_BYTE || tx_data == `SBL_NAK_BYTE)
    else $error("answer byte is neither ACK nor NAK");

  bad_sum_nak_a: assert property (
    bad_packet_s |=> state == sbl_pkg::S_ACK && tx_data == `SBL_NAK_BYTE)
    else $error("bad packet not answered with NAK");

  unknown_ack_a: assert property (
    state == sbl_pkg::S_RX && !sync_hit && pkt.done && pkt.good &&
    (pkt.payload[0] < `SBL_CMD_PING || pkt.payload[0] > `SBL_CMD_RESET)
    |=> tx_data == `SBL_ACK_BYTE && last_result == `SBL_RES_UNKNOWN_CMD)
    else $error("unknown command not ACKed with failure stored");

  ping_result_a: assert property (
    state == sbl_pkg::S_RX && !sync_hit && pkt.done && pkt.good &&
    pkt.payload[0] == `SBL_CMD_PING && pkt.count == 8'h01 |=>
      last_result == `SBL_RES_SUCCESS && tx_data == `SBL_ACK_BYTE)
    else $error("probe did not store success");

  pkt_no_gap_a: assert property (
    state == sbl_pkg::S_PKT |-> tx_vec != 2'b00)
    else $error("gap inside outgoing packet");

  port_lock_a: assert property (
    port_sel != sbl_pkg::PORT_NONE |=> port_sel == $past(port_sel))
    else $error("locked port changed");

  nak_keep_addr_a: assert property (
    bad_packet_s |=> ##1 prog_addr == $past(prog_addr, 2) &&
      prog_left == $past(prog_left, 2))
    else $error("program address moved on NAK");

  run_after_ack_a: assert property (
    ack_taken_s ##0 post == sbl_pkg::POST_RUN |=> run_req && tx_vec == 2'b00)
    else $error("jump not issued right after ACK");

  reset_after_ack_a: assert property (
    $rose(soft_reset) |-> $past(tx_take) &&
      $past(tx_data) == `SBL_ACK_BYTE)
    else $error("restart without prior ACK");

  erase_first_a: assert property (
    state == sbl_pkg::S_ERASE && !flash_erase_done |=>
      state == sbl_pkg::S_ERASE && tx_vec == 2'b00)
    else $error("answer sent before erase finished");

  sync_reply_a: assert property (
    sync_hit |=> state == sbl_pkg::S_SYNC && tx_vec == 2'b01 &&
      tx_data == `SBL_ACK_BYTE)
    else $error("sync pattern not answered");

endmodule : sbl_loader_top

`default_nettype wire

// ### design/sbl_packet_rx.sv
// sbl_packet_rx: gathers one packet, skips zero padding, checks the sum
// assumes: bytes arrive one per valid cycle; enable low restarts it
`timescale 1ns/100ps
`default_nettype none
`include "sbl_params.svh"

module sbl_packet_rx (
  input wire logic ref_clk,
  input wire logic sys_rst,
  sbl_pkt_if.rx_side pkt
);

  sbl_pkg::sbl_rx_state_type pstate;
  logic [7:0] left;
  logic [7:0] len;
  logic [7:0] sum_rx;
  logic [7:0] acc;
  logic [7:0] idx;

  // ----------------------------------------------------------------------
  // packet gathering
  // ----------------------------------------------------------------------
  // length, sum and payload bytes in turn; done pulses on the last byte
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pstate <= sbl_pkg::P_LEN;
      left <= 8'h00;
      len <= 8'h00;
      sum_rx <= 8'h00;
      acc <= 8'h00;
      idx <= 8'h00;
      pkt.done <= 1'b0;
      pkt.good <= 1'b0;
      pkt.count <= 8'h00;
    end else begin
      pkt.done <= 1'b0;
      if (!pkt.enable) begin
        pstate <= sbl_pkg::P_LEN;
      end else if (pkt.byte_valid) begin
        unique case (pstate)
          sbl_pkg::P_LEN: begin
            if (pkt.byte_data != 8'h00) begin
              len <= pkt.byte_data;
              left <= pkt.byte_data - 8'h02;
              acc <= 8'h00;
              idx <= 8'h00;
              if (pkt.byte_data == 8'h01) begin
                pkt.done <= 1'b1;
                pkt.good <= 1'b0;
                pkt.count <= 8'h00;
              end else begin
                pstate <= sbl_pkg::P_SUM;
              end
            end
          end
          sbl_pkg::P_SUM: begin
            sum_rx <= pkt.byte_data;
            if (left == 8'h00) begin
              pkt.done <= 1'b1;
              pkt.good <= 1'b0; // no command byte at all
              pkt.count <= 8'h00;
              pstate <= sbl_pkg::P_LEN;
            end else begin
              pstate <= sbl_pkg::P_DATA;
            end
          end
          sbl_pkg::P_DATA: begin
            acc <= acc + pkt.byte_data;
            idx <= idx + 8'h01;
            left <= left - 8'h01;
            if (left == 8'h01) begin
              pkt.done <= 1'b1;
              pkt.good <= ((acc + pkt.byte_data) == sum_rx) && (len > 8'h02);
              pkt.count <= len - 8'h02;
              pstate <= sbl_pkg::P_LEN;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // payload storage
  // ----------------------------------------------------------------------
  // bytes beyond the last slot are summed but not kept
  genvar g;
  generate
    for (g = 0; g < `SBL_PAYLOAD_SLOTS; g++) begin : g_slot
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          pkt.payload[g] <= 8'h00;
        end else if (pkt.enable && pkt.byte_valid &&
                     pstate == sbl_pkg::P_DATA && idx == 8'(g)) begin
          pkt.payload[g] <= pkt.byte_data;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sum_good_a: assert property (
    pkt.done && pkt.good |->
      $past(acc) + $past(pkt.byte_data) == $past(sum_rx))
    else $error("good packet with wrong sum");

  zero_skip_a: assert property (
    pstate == sbl_pkg::P_LEN && pkt.enable && pkt.byte_valid &&
    pkt.byte_data == 8'h00 |=> pstate == sbl_pkg::P_LEN && !pkt.done)
    else $error("zero padding taken as length");

endmodule : sbl_packet_rx

`default_nettype wire

// ### design/sbl_params.svh
// sbl_params.svh: byte codes, packet sizes and result codes of the loader
// assumes: included by bare name from every design file that needs it
`ifndef SBL_PARAMS_SVH
`define SBL_PARAMS_SVH

// ----------------------------------------------------------------------
// answer and sync bytes
// ----------------------------------------------------------------------
`define SBL_ACK_BYTE 8'hCC
`define SBL_NAK_BYTE 8'h33
`define SBL_SYNC_BYTE 8'h55
`define SBL_SYNC_COUNT 2'h2

// ----------------------------------------------------------------------
// command codes and their payload sizes (command byte included, except in SBL_MAX_DATA)
// ----------------------------------------------------------------------
`define SBL_CMD_PING 8'h20
`define SBL_CMD_DOWNLOAD 8'h21
`define SBL_CMD_RUN 8'h22
`define SBL_CMD_STATUS 8'h23
`define SBL_CMD_SEND_DATA 8'h24
`define SBL_CMD_RESET 8'h25
`define SBL_PING_PAYLOAD 8'h01
`define SBL_DOWNLOAD_PAYLOAD 8'h09
`define SBL_RUN_PAYLOAD 8'h05
`define SBL_MAX_DATA 8'h08
`define SBL_PAYLOAD_SLOTS 9
`define SBL_STATUS_LEN 8'h03

// ----------------------------------------------------------------------
// last-command result codes and target range
// ----------------------------------------------------------------------
`define SBL_RES_SUCCESS 8'h40
`define SBL_RES_UNKNOWN_CMD 8'h41
`define SBL_RES_INVALID_CMD 8'h42
`define SBL_RES_INVALID_ADDR 8'h43
`define SBL_FLASH_BYTES 32'h0002_0000

`endif

// ### design/sbl_pkg.sv
// sbl_pkg: state and port-selection types of the loader
// assumes: compiled before the interface and the modules
package sbl_pkg;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    S_RX, S_ERASE, S_PROG, S_ACK, S_PKT, S_HOST, S_SYNC
  } sbl_state_type;

  typedef enum logic [1:0] {PORT_NONE, PORT_UART, PORT_SSI} sbl_port_type;

  typedef enum logic [1:0] {
    POST_NONE, POST_STATUS, POST_RUN, POST_RESET
  } sbl_post_type;

  typedef enum logic [1:0] {P_LEN, P_SUM, P_DATA} sbl_rx_state_type;

endpackage : sbl_pkg

// ### design/sbl_pkt_if.sv
// sbl_pkt_if: byte feed into the packet receiver and the parsed packet out
// assumes: one clock, driven by the loader core and the receiver
`timescale 1ns/100ps
`default_nettype none

interface sbl_pkt_if;
  logic enable;
  logic byte_valid;
  logic [7:0] byte_data;
  logic done;
  logic good;
  logic [7:0] count;
  logic [7:0] payload [0:8];

  modport rx_side (input enable, byte_valid, byte_data,
                   output done, good, count, payload);
  modport core_side (output enable, byte_valid, byte_data,
                     input done, good, count, payload);
endinterface : sbl_pkt_if

`default_nettype wire

// ### test/sbl_host_model.sv
// sbl_host_model: host side taking the loader's answer bytes
// assumes: one clock; ready stalls on alternate cycles while slow is high
`timescale 1ns/100ps
`default_nettype none

module sbl_host_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic [7:0] got,
  output logic [7:0] got_cnt
);
  // ready, stalled every other cycle when slow
  always_ff @(posedge ref_clk) begin
    if (sys_rst) tx_ready <= 1'b0;
    else tx_ready <= slow ? ~tx_ready : 1'b1;
  end

  // keep the last non-zero byte taken and count them
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      got <= 8'h00;
      got_cnt <= 8'h00;
    end else if (tx_valid && tx_ready && tx_data != 8'h00) begin
      got <= tx_data;
      got_cnt <= got_cnt + 8'h01;
    end
  end
endmodule : sbl_host_model

`default_nettype wire

// ### test/testbench.sv
// testbench: packet level checks of the loader top
// assumes: flash engines answer one cycle after each request; the host model takes answers
`timescale 1ns/100ps
`default_nettype none

module testbench;
  typedef logic [7:0] sbl_bytes_type [$];
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic urv = 1'b0, srv = 1'b0, slow = 1'b0, ed = 1'b0, wd = 1'b0, up = 1'b0;
  logic [7:0] ud = 8'h00, sd = 8'h00, got, gcnt, tx, wdat, c;
  logic utv, stv, rdy, ereq, wreq, rreq, srst;
  logic [31:0] ea, es, wa, ra, xa = 32'h100;
  int error_cnt = 0, check_count = 0, ecnt = 0, wcnt = 0, rcnt = 0, scnt = 0;
  logic [23:0] pk [4] = '{24'h032020, 24'h033030, 24'h032424, 24'h032120};
  logic [15:0] ex [4] = '{16'hCC40, 16'hCC41, 16'hCC42, 16'h3342};

  always #2 ref_clk = ~ref_clk;

  sbl_loader_top u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .uart_rx_valid(urv), .uart_rx_data(ud), .uart_tx_ready(rdy),
    .uart_tx_valid(utv), .ssi_rx_valid(srv), .ssi_rx_data(sd),
    .ssi_tx_ready(rdy), .ssi_tx_valid(stv), .tx_data(tx),
    .flash_erase_req(ereq), .flash_erase_addr(ea), .flash_erase_size(es),
    .flash_erase_done(ed), .flash_wr_req(wreq), .flash_wr_addr(wa),
    .flash_wr_data(wdat), .flash_wr_done(wd), .run_req(rreq),
    .run_addr(ra), .soft_reset(srst));
  sbl_host_model u_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .slow(slow),
    .tx_valid(utv | stv), .tx_data(tx), .tx_ready(rdy), .got(got),
    .got_cnt(gcnt));

  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
    end
  endtask : chk

  task test_done();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  // one byte per cycle; the clocked port gets a zero pad first
  task send(input logic u, input sbl_bytes_type q);
    if (!u) q.push_front(8'h00);
    foreach (q[k]) begin
      @(posedge ref_clk);
      urv <= u;
      srv <= !u;
      ud <= q[k];
      sd <= q[k];
    end
    @(posedge ref_clk);
    urv <= 1'b0;
    srv <= 1'b0;
  endtask : send

  // wait at most lim cycles for the next byte taken by the host
  task ans(input logic [7:0] exp, input int lim);
    logic [7:0] n;
    n = gcnt;
    for (int k = 0; k < lim && gcnt == n; k++) begin
      @(posedge ref_clk);
      #1;
    end
    if (gcnt == n) begin
      error_cnt++;
      $display("CHECK FAILED answer exp %h seen none", exp);
      test_done();
    end else begin
      chk("answer", got, exp);
    end
  endtask : ans

  task query(input logic [7:0] res);
    send(1'b0, '{8'h03, 8'h23, 8'h23});
    ans(8'hCC, 300);
    ans(8'h03, 3);
    ans(res, 3);
    ans(res, 3);
    send(1'b0, '{8'hCC});
    repeat (2) @(posedge ref_clk);
  endtask : query

  // flash engines, run and restart monitors
  always @(posedge ref_clk) begin
    ed <= ereq && !ed;
    wd <= wreq && !wd;
    if (ed) begin
      ecnt++;
      chk("erase_addr", ea, 32'h100);
      chk("erase_size", es, 32'h5);
    end
    if (wd) begin
      chk("wr_addr", wa, xa);
      chk("wr_data", {24'h0, wdat}, 32'hA0 + xa - 32'h100);
      xa = xa + 1;
      wcnt++;
    end
    if (rreq) begin
      rcnt++;
      chk("run_addr", ra, 32'h1234);
    end
    if (srst) scnt++;
    // answers only ever leave on the locked port
    if (utv || stv)
      chk("tx_port", {30'h0, utv, stv}, {30'h0, up, !up});
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk("idle", {26'h0, utv, stv, ereq, wreq, rreq, srst}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      send(1'b0, '{pk[i][23:16], pk[i][15:8], pk[i][7:0]});
      ans(ex[i][15:8], 300);
      query(ex[i][7:0]);
    end
    slow <= 1'b1;
    send(1'b0, '{8'h0B, 8'h27, 8'h21, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h05});
    ans(8'hCC, 300);
    chk("erase_cnt", ecnt, 1);
    query(8'h40);
    send(1'b0, '{8'h06, 8'h07, 8'h24, 8'hA0, 8'hA1, 8'hA2});
    ans(8'hCC, 300);
    send(1'b0, '{8'h05, 8'h00, 8'h24, 8'hA3, 8'hA4});
    ans(8'h33, 300);
    send(1'b0, '{8'h05, 8'h6B, 8'h24, 8'hA3, 8'hA4});
    ans(8'hCC, 300);
    send(1'b0, '{8'h04, 8'hC9, 8'h24, 8'hA5});
    ans(8'hCC, 300);
    query(8'h42);
    chk("wr_cnt", wcnt, 5);
    send(1'b0, '{8'h0B, 8'h22, 8'h21, 8'h00, 8'h01, 8'hFF, 8'hFF, 8'h00,
      8'h00, 8'h00, 8'h02});
    ans(8'hCC, 300);
    query(8'h43);
    chk("erase_cnt", ecnt, 1);
    send(1'b0, '{8'h07, 8'h68, 8'h22, 8'h00, 8'h00, 8'h12, 8'h34});
    ans(8'hCC, 300);
    chk("run_early", rcnt, 0);
    repeat (3) @(posedge ref_clk);
    chk("run_cnt", rcnt, 1);
    send(1'b0, '{8'h03, 8'h25, 8'h25});
    ans(8'hCC, 300);
    chk("rst_early", scnt, 0);
    repeat (3) @(posedge ref_clk);
    chk("rst_cnt", scnt, 1);
    c = gcnt;
    send(1'b1, '{8'h03, 8'h20, 8'h20});
    repeat (50) @(posedge ref_clk);
    chk("ssi_lock", gcnt, c);
    sys_rst <= 1'b1;
    up <= 1'b1; // answers now expected on the async port
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    send(1'b1, '{8'h55, 8'h55});
    ans(8'hCC, 300);
    c = gcnt;
    send(1'b0, '{8'h03, 8'h20, 8'h20});
    repeat (50) @(posedge ref_clk);
    chk("uart_lock", gcnt, c);
    send(1'b1, '{8'h03, 8'h20, 8'h20});
    ans(8'hCC, 300);
    test_done();
  end
endmodule : testbench

`default_nettype wire
